// ==== rtl/mtsc_map.vh ====
// constants for the passive serial configuration target
`ifndef MTSC_MAP_VH
`define MTSC_MAP_VH
`define MTSC_CLK_PERIOD_NS 40
`define MTSC_RESET_TIMEOUT_US 40
`define MTSC_RESET_TIMEOUT_CYC ((`MTSC_RESET_TIMEOUT_US * 1000) / `MTSC_CLK_PERIOD_NS)
`define MTSC_IMAGE_BITS 32'h0000_0100
`define MTSC_INIT_CYC 16'h0040
`define MTSC_ST_RESET 3'h0
`define MTSC_ST_WAIT 3'h1
`define MTSC_ST_LOAD 3'h2
`define MTSC_ST_DONE 3'h3
`define MTSC_ST_INIT 3'h4
`define MTSC_ST_USER 3'h5
`define MTSC_ST_ERROR 3'h6
`endif

// ==== rtl/mtsc_target.v ====
// one configuration target on a passive serial lane
`timescale 1ns/1ps
// How it works
// R1: loader picks lane width from target count
// R2: three targets: lane 3 unused
// R3: one lane may feed two chained targets
// R4: identical data: enable held active, lockstep
// R5: identical data: chain enable output unconnected
// R6: master loader drives shift clock everywhere
// R7: cascade output drives next loader select
// R8: loader drives cascade low when emptied
// R9: next loader starts within one clock
// R10: shared status error halts whole chain
// R11: missing done: master forces all resets
// R12: init request drives reconfiguration request
// R13: only first loader drives init request
// R14: done and status lines tied chain-wide
// R15: initialization clocked by oscillator or user clock
// R16: only older loaders may cascade
// R17: status released after at most 40 us
// R18: finished target drives chain enable out low
// R19: sample lane bit each shift clock rising edge; code skips an edge, dropping its bit, if the buffer is full at bit eight
// state codes and counts must be known before the parameter list
`include "mtsc_map.vh"
module mtsc_target #(
  parameter IMAGE_BITS = `MTSC_IMAGE_BITS,
  parameter TIMEOUT_CYC = `MTSC_RESET_TIMEOUT_CYC,
  parameter INIT_CYC = `MTSC_INIT_CYC,
  parameter AUTO_RESTART = 1
) (
  // clock and reset
  input wire clk,
  input wire nrst,
  // configuration pins from the loader and the chain
  input wire cfg_shift_clock,
  input wire serial_lane0,
  input wire chain_enable_in_n,
  input wire reconfig_req_n,
  input wire status_in_n,
  input wire done_in,
  input wire data_error,
  // initialization clock selection
  input wire user_init_clock,
  input wire use_user_clock,
  // open-drain status and done pins, driven chain enable output
  output wire status_out,
  output wire status_oe,
  output wire done_out,
  output wire done_oe,
  output reg chain_enable_out_n,
  // configuration word stream to the fabric, user mode flag
  output wire [7:0] cfg_word,
  output wire cfg_word_valid,
  input wire cfg_word_ready,
  output wire user_mode
);
  // two-flop synchronisers for every pin but data_error, use_user_clock and cfg_word_ready
  reg [6:0] s1_r;
  reg [6:0] s2_r;
  wire [6:0] pins = {user_init_clock, done_in, status_in_n, reconfig_req_n,
                     chain_enable_in_n, serial_lane0, cfg_shift_clock};
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s1_r <= 7'h00;
      s2_r <= 7'h00;
    end else begin
      s1_r <= pins;
      s2_r <= s1_r;
    end
  end
  wire cfg_shift_clock_s = s2_r[0];
  wire data_s = s2_r[1];
  wire ce_n_s = s2_r[2];
  wire cfg_n_s = s2_r[3];
  wire st_n_s = s2_r[4];
  wire done_s = s2_r[5];
  wire uclk_s = s2_r[6];
  reg cfg_shift_clock_d_r;
  reg uclk_d_r;
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_shift_clock_d_r <= 1'b0;
      uclk_d_r <= 1'b0;
    end else begin
      cfg_shift_clock_d_r <= cfg_shift_clock_s;
      uclk_d_r <= uclk_s;
    end
  end
  wire cfg_shift_clock_rise = cfg_shift_clock_s & ~cfg_shift_clock_d_r;
  // initialization tick: internal oscillator is clk itself
  wire init_tick = use_user_clock ? (uclk_s & ~uclk_d_r) : 1'b1; // [R15]

  reg [2:0] state_r;
  reg [31:0] cnt_r;
  reg [7:0] shift_r;
  reg [2:0] bitn_r;
  reg wr_r;
  wire buf_ready;
  // status driven low in reset and error; done low until loaded and in error
  assign status_out = 1'b0;
  assign status_oe = (state_r == `MTSC_ST_RESET) || (state_r == `MTSC_ST_ERROR);
  assign done_out = 1'b0;
  assign done_oe = (state_r == `MTSC_ST_RESET) || (state_r == `MTSC_ST_WAIT) ||
                   (state_r == `MTSC_ST_LOAD) || (state_r == `MTSC_ST_ERROR);
  assign user_mode = (state_r == `MTSC_ST_USER);

  // main configuration sequence
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= `MTSC_ST_RESET;
      cnt_r <= 32'h0000_0000;
      shift_r <= 8'h00;
      bitn_r <= 3'h0;
      wr_r <= 1'b0;
      chain_enable_out_n <= 1'b1;
    end else begin
      wr_r <= 1'b0;
      if (!cfg_n_s && state_r != `MTSC_ST_RESET) begin
        state_r <= `MTSC_ST_RESET; // reconfiguration request [R12]
        cnt_r <= 32'h0000_0000;
        chain_enable_out_n <= 1'b1;
      end else begin
        case (state_r)
          `MTSC_ST_RESET: begin
            chain_enable_out_n <= 1'b1;
            bitn_r <= 3'h0;
            if (cnt_r < TIMEOUT_CYC - 1) begin
              cnt_r <= cnt_r + 32'h0000_0001;
            end else if (cfg_n_s) begin
              state_r <= `MTSC_ST_WAIT; // release within 40 us [R17]
              cnt_r <= 32'h0000_0000;
            end
          end
          `MTSC_ST_WAIT: begin
            // whole chain starts only once shared status is high [R14]
            if (st_n_s && !ce_n_s) begin
              state_r <= `MTSC_ST_LOAD; // [R4]
            end
          end
          `MTSC_ST_LOAD: begin
            if (!st_n_s || data_error) begin
              state_r <= `MTSC_ST_ERROR; // any error halts all [R10] [R11]
              cnt_r <= 32'h0000_0000;
            end else if (cfg_shift_clock_rise && buf_ready) begin
              // with the buffer full at the eighth bit this edge goes unsampled and its bit is dropped
              shift_r <= {shift_r[6:0], data_s}; // [R19]
              bitn_r <= bitn_r + 3'h1;
              wr_r <= (bitn_r == 3'h7);
              cnt_r <= cnt_r + 32'h0000_0001;
              if (cnt_r == IMAGE_BITS - 1) begin
                state_r <= `MTSC_ST_DONE;
              end
            end
          end
          `MTSC_ST_DONE: begin
            cnt_r <= 32'h0000_0000;
            if (!st_n_s) begin
              // no hand-on when the chain fails right at the last bit
              chain_enable_out_n <= 1'b1;
              state_r <= `MTSC_ST_ERROR; // [R10]
            end else begin
              chain_enable_out_n <= 1'b0; // hand on to next target [R18]
              if (done_s) begin
                state_r <= `MTSC_ST_INIT; // all targets done together [R14]
              end
            end
          end
          `MTSC_ST_INIT: begin
            if (init_tick) begin
              cnt_r <= cnt_r + 32'h0000_0001; // [R15]
              if (cnt_r == INIT_CYC - 1) begin
                state_r <= `MTSC_ST_USER;
              end
            end
          end
          `MTSC_ST_USER: begin
            state_r <= `MTSC_ST_USER;
          end
          `MTSC_ST_ERROR: begin
            chain_enable_out_n <= 1'b1;
            bitn_r <= 3'h0; // a cut frame restarts on a word boundary
            if (cnt_r < TIMEOUT_CYC - 1) begin
              cnt_r <= cnt_r + 32'h0000_0001;
            end else if (AUTO_RESTART != 0) begin
              state_r <= `MTSC_ST_WAIT; // release status after time-out [R17]
              cnt_r <= 32'h0000_0000;
            end
          end
          default: begin
            state_r <= `MTSC_ST_RESET;
          end
        endcase
      end
    end
  end

  // two-entry word buffer toward the fabric
  reg [7:0] mem_r [0:1];
  reg wp_r;
  reg rp_r;
  reg [1:0] cnt2_r;
  assign buf_ready = (cnt2_r != 2'h2) || !(bitn_r == 3'h7);
  wire push = wr_r;
  wire pop = cfg_word_valid && cfg_word_ready;
  assign cfg_word_valid = (cnt2_r != 2'h0);
  assign cfg_word = mem_r[rp_r];
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt2_r <= 2'h0;
      mem_r[0] <= 8'h00;
      mem_r[1] <= 8'h00;
    end else begin
      if (push) begin
        mem_r[wp_r] <= shift_r;
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      cnt2_r <= cnt2_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// ==== sim/mtsc_loader.sv ====
// loader model: shift clock and one data lane
`timescale 1ns/1ps
module mtsc_loader (
  // shared status wire in, lane pins out
  input wire st_n,
  output reg sclk = 1'b0,
  output reg lane = 1'b0
);
  // sole loader: select held active, cascade output left open
  // clock idles low between frames; stops on a chain error
  task send(input logic [7:0] b, input int n);
    for (int i = 7; i > 7 - n && st_n; i--) begin
      lane = b[i];
      #160 sclk = 1'b1;
      #160 sclk = 1'b0;
    end
    lane = ~lane; // no stale bit left on the lane
  endtask
endmodule

// ==== sim/mtsc_target_sva.sv ====
// port assertions for the configuration target
`timescale 1ns/1ps
module mtsc_target_sva #(parameter TIMEOUT_CYC = 20) (
  // clock, reset, chain wires
  input wire clk, nrst, reconfig_req_n, status_in_n, done_in, chain_enable_in_n, done_out,
  // target outputs and stream
  input wire status_out, status_oe, done_oe, chain_enable_out_n, user_mode, cfg_word_valid, cfg_word_ready,
  input wire [7:0] cfg_word
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // length of a status pull with no restart request
  int hold_r;
  always @(posedge clk or negedge nrst)
    if (!nrst) hold_r <= 0;
    else hold_r <= (status_oe && reconfig_req_n) ? hold_r + 1 : 0;
  AST_TMO: assert property (hold_r <= TIMEOUT_CYC + 8) else $error("status stuck");
  AST_ERR: assert property ($fell(status_in_n) && !status_oe && done_oe && !chain_enable_in_n
    && !$past(chain_enable_in_n, 4) |-> ##[1:4] status_oe) else $error("error missed");
  AST_SOUT: assert property (!status_out && !done_out) else $error("open drain high");
  AST_RST: assert property (!reconfig_req_n && !$past(reconfig_req_n) && !$past(reconfig_req_n, 2)
    && !$past(reconfig_req_n, 3) |-> status_oe && done_oe) else $error("request ignored");
  AST_HOLD: assert property (cfg_word_valid && !cfg_word_ready |=> cfg_word_valid && $stable(cfg_word))
    else $error("word lost");
  AST_RCF: assert property ($fell(reconfig_req_n) |-> ##[1:3] (status_oe && done_oe && chain_enable_out_n))
    else $error("restart missed");
  AST_USR: assert property (user_mode |-> !done_oe && !status_oe && !chain_enable_out_n)
    else $error("bad user mode");
  AST_DONE: assert property ($rose(user_mode) |-> done_in && $past(done_in)) else $error("early user");
  AST_CEO: assert property ($fell(chain_enable_out_n) |-> !status_oe) else $error("enable on error");
endmodule
bind mtsc_target mtsc_target_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) i_sva (.*);

// ==== sim/testbench.sv ====
// self-checking bench for one target and its loader
`timescale 1ns/1ps
module testbench;
  logic clk = 0, nrst = 0, req_n = 1, en_n = 0, err = 0, ext = 0, uclk = 0, use_u = 0, rdy = 0;
  logic soe, doe, ceo_n, vld, um;
  logic [7:0] word;
  logic [7:0] exp_q[$];
  int mismatches = 0, n_tests = 0;
  wire sclk, lane;
  wire st_n = ~soe & ~ext; // pulled-up shared status
  // one target alone on lane 0, spare lanes idle, no daisy chain
  // chain enable output only watched, never passed on
  mtsc_target #(.IMAGE_BITS(16), .TIMEOUT_CYC(20), .INIT_CYC(8)) i_mtsc_target (.clk, .nrst,
    .cfg_shift_clock(sclk), .serial_lane0(lane), .chain_enable_in_n(en_n), .reconfig_req_n(req_n),
    .status_in_n(st_n), .done_in(~doe), .data_error(err), .user_init_clock(uclk), .use_user_clock(use_u),
    .status_out(), .status_oe(soe), .done_out(), .done_oe(doe), .chain_enable_out_n(ceo_n),
    .cfg_word(word), .cfg_word_valid(vld), .cfg_word_ready(rdy), .user_mode(um));
  mtsc_loader i_mtsc_loader (.st_n, .sclk, .lane);
  initial forever #20 clk = ~clk;
  initial forever #100 uclk = ~uclk;
  // random stalls delay pops; words come 64 cycles apart, so the buffer never fills
  always @(negedge clk) rdy <= ($urandom % 3) != 0;
  always @(posedge clk) if (nrst && vld === 1'b1 && rdy)
    chk("cfg_word", exp_q.size() ? exp_q.pop_front() : 8'hXX, word);
  task chk(input string s, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  task close_out;
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // k=0: status released, k=1: user mode
  task wt(input int k);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge clk);
      if (k ? um === 1'b1 : (soe === 1'b0 && st_n === 1'b1)) break;
    end
    if (i == 3000) begin
      mismatches++;
      close_out;
    end
  endtask
  task frame;
    logic [7:0] b;
    repeat (2) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      i_mtsc_loader.send(b, 8);
    end
  endtask
  initial begin
    void'($urandom(32'h90C5));
    repeat (6) @(negedge clk);
    nrst = 1;
    wt(0);
    frame;
    wt(1);
    for (int k = 0; k < 2; k++) begin
      chk("ceo_n", 8'h00, {7'h00, ceo_n});
      req_n = 0;
      repeat (4) @(negedge clk);
      req_n = 1;
      use_u = k[0];
      wt(0);
      i_mtsc_loader.send(8'hA5, 4);
      {ext, err} = k ? 2'b01 : 2'b10;
      repeat (4) @(negedge clk);
      {ext, err} = 2'b00;
      wt(0);
      frame;
      wt(1);
    end
    // let the last word drain through random stalls
    repeat (20) @(negedge clk);
    chk("left", 8'h00, 8'(exp_q.size()));
    close_out;
  end
endmodule
